//--- src/core_regs_pkg.sv
// Package with the data-memory map, field positions and reset values of the core register slice
package core_regs_pkg;
	// Register addresses in the data map
	localparam logic [7:0] ADDR_INDIRECT_WINDOW = 8'h00;
	localparam logic [7:0] ADDR_BANK_SELECT     = 8'h01;
	localparam logic [7:0] ADDR_PC_LOW          = 8'h02;
	localparam logic [7:0] ADDR_STATUS          = 8'h03;
	localparam logic [7:0] ADDR_POINTER         = 8'h04;
	localparam logic [7:0] ADDR_PORT_A          = 8'h05;
	localparam logic [7:0] ADDR_PORT_B          = 8'h06;
	localparam logic [7:0] ADDR_PORT_C          = 8'h08;
	localparam logic [7:0] ADDR_SPECIAL_LAST    = 8'h4F;
	localparam logic [7:0] ADDR_SHARED_FIRST    = 8'h50;
	localparam logic [7:0] ADDR_SHARED_LAST     = 8'h7F;
	localparam logic [7:0] ADDR_BANKED_FIRST    = 8'h80;
	// Bank select fields
	localparam int BSEL_SPECIAL_BIT = 4;
	localparam int BSEL_GENERAL_BIT = 0;
	localparam logic [7:0] BSEL_MASK = 8'h11;
	// Status fields
	localparam int ST_IRQ_EN    = 7;
	localparam int ST_NEG       = 6;
	localparam int ST_SIGNED_WR = 5;
	localparam int ST_TIMEOUT   = 4;
	localparam int ST_PWR_DOWN  = 3;
	localparam int ST_ZERO      = 2;
	localparam int ST_HALF      = 1;
	localparam int ST_CARRY     = 0;
	// Reset values
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h18;
	// Storage sizes: shared 48 bytes, banked 2 x 128 bytes
	localparam int SHARED_WORDS = 48;
	localparam int BANKED_WORDS = 256;

	// Access request from the instruction datapath
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} mem_req_type;

	// Flag update from an executed result
	typedef struct packed {
		logic upd;
		logic neg;
		logic signed_wrap;
		logic zero;
		logic half_carry;
		logic carry;
	} flag_upd_type;

	// Core events
	typedef struct packed {
		logic irq_mask;
		logic irq_unmask;
		logic irq_entry;
		logic power_down;
		logic wdog_clear;
		logic wdog_timeout;
	} core_evt_type;

	// Address classes of the data map
	typedef enum {
		CLS_WINDOW, CLS_BANKSEL, CLS_PCL, CLS_STATUS, CLS_POINTER,
		CLS_PORT_A, CLS_PORT_B, CLS_PORT_C, CLS_SHARED, CLS_BANKED, CLS_UNUSED
	} addr_class_type;
endpackage

//--- src/status_flag_unit.sv
// Status register with flag updates, interrupt gate and sleep/watchdog bits
`timescale 1ns/1ns
`default_nettype none
module status_flag_unit
(
	input  wire logic                        i_sys_clk,    // System clock
	input  wire logic                        i_rst_n,      // Synchronised reset, active low
	input  wire logic                        i_wr,         // Software write to status
	input  wire logic [7:0]                  i_wdata,      // Write data
	input  wire core_regs_pkg::flag_upd_type i_flags,      // Result flags
	input  wire core_regs_pkg::core_evt_type i_evt,        // Core events
	output logic      [7:0]                  o_status      // Status value
);
	import core_regs_pkg::*;

	logic [7:0] status_r;
	logic [7:0] status_nxt;

	// Priority: software write, then result flags, then events which win last
	always_comb
	begin
		status_nxt = status_r;
		if (i_wr)
			status_nxt = i_wdata;                                  // [RULE_16]
		if (i_flags.upd)
		begin
			status_nxt[ST_NEG]       = i_flags.neg;                // [RULE_06] [RULE_16]
			status_nxt[ST_SIGNED_WR] = i_flags.signed_wrap;        // [RULE_07]
			status_nxt[ST_ZERO]      = i_flags.zero;               // [RULE_10]
			status_nxt[ST_HALF]      = i_flags.half_carry;         // [RULE_11]
			status_nxt[ST_CARRY]     = i_flags.carry;              // [RULE_11]
		end
		if (i_evt.irq_unmask)
			status_nxt[ST_IRQ_EN] = 1'b1;                          // [RULE_05]
		if (i_evt.irq_mask || i_evt.irq_entry)
			status_nxt[ST_IRQ_EN] = 1'b0;                          // [RULE_05]
		if (i_evt.power_down)
		begin
			status_nxt[ST_TIMEOUT]  = 1'b1;                        // [RULE_08]
			status_nxt[ST_PWR_DOWN] = 1'b0;                        // [RULE_09]
		end
		if (i_evt.wdog_clear)
		begin
			status_nxt[ST_TIMEOUT]  = 1'b1;                        // [RULE_08]
			status_nxt[ST_PWR_DOWN] = 1'b1;                        // [RULE_09]
		end
		// Time-out event wins so a watchdog expiry is never lost
		if (i_evt.wdog_timeout)
			status_nxt[ST_TIMEOUT] = 1'b0;                         // [RULE_08]
	end

	// Power-up leaves time-out and power-down set
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			status_r <= RST_STATUS;                                // [RULE_08] [RULE_09]
		else
			status_r <= status_nxt;
	end

	assign o_status = status_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_timeout_clear;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_evt.wdog_timeout |=> !status_r[ST_TIMEOUT];
	endproperty
	a_timeout_clear: assert property (p_timeout_clear) else $error("time-out bit not cleared"); // [RULE_08]

	property p_sleep_bits;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_evt.power_down && !i_evt.wdog_clear && !i_evt.wdog_timeout) |=>
			(status_r[ST_TIMEOUT] && !status_r[ST_PWR_DOWN]);
	endproperty
	a_sleep_bits: assert property (p_sleep_bits) else $error("sleep did not set T and clear P"); // [RULE_09]

	property p_wdc_bits;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_evt.wdog_clear && !i_evt.wdog_timeout) |=> (status_r[ST_TIMEOUT] && status_r[ST_PWR_DOWN]);
	endproperty
	a_wdc_bits: assert property (p_wdc_bits) else $error("watchdog clear did not set T and P"); // [RULE_08]

	property p_irq_gate;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_evt.irq_mask || i_evt.irq_entry) |=> !status_r[ST_IRQ_EN];
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt gate not closed"); // [RULE_05]

	property p_irq_open;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_evt.irq_unmask && !i_evt.irq_mask && !i_evt.irq_entry) |=> status_r[ST_IRQ_EN];
	endproperty
	a_irq_open: assert property (p_irq_open) else $error("interrupt gate not opened"); // [RULE_05]

	property p_flag_copy;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_flags.upd |=> (status_r[ST_NEG] == $past(i_flags.neg) && status_r[ST_ZERO] == $past(i_flags.zero)
			&& status_r[ST_CARRY] == $past(i_flags.carry) && status_r[ST_HALF] == $past(i_flags.half_carry)
			&& status_r[ST_SIGNED_WR] == $past(i_flags.signed_wrap));
	endproperty
	a_flag_copy: assert property (p_flag_copy) else $error("result flags not captured"); // [RULE_06]

	property p_flags_hold;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(!i_flags.upd && !i_wr) |=> $stable(status_r[2:0]) && $stable(status_r[6:5]);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flags changed without a result"); // [RULE_16]
endmodule
`default_nettype wire

//--- src/core_status_indirect_regs.sv
// Core special-register slice: data map decode, indirect window, bank select, status, storage
//
// Contract
// [RULE_01] The window, bank select, PC low, status and pointer sit at addresses 0x00 to 0x04.
// [RULE_02] 0x50-0x7F is storage shared by both banks, 0x80-0xFF is storage with one copy per bank.
// [RULE_03] Bank select bit 4 picks bank 0 or bank 1 for special registers at 0x05-0x4F.
// [RULE_04] Bank select bit 0 picks which copy of the banked storage is used.
// [RULE_05] Status bit 7 is the interrupt gate, cleared by mask or interrupt entry, set by unmask.
// [RULE_06] Status bit 6 copies the result's top bit.
// [RULE_07] Status bit 5 is set on signed overflow of a result and cleared otherwise.
// [RULE_08] Status bit 4 is set by sleep, watchdog clear and power-up, and cleared by watchdog time-out.
// [RULE_09] Status bit 3 is set at power-on and by watchdog clear, and cleared by sleep.
// [RULE_10] Status bit 2 is set for a zero result and cleared for a nonzero one.
// [RULE_11] Status bit 1 takes the half carry and bit 0 the full carry.
// [RULE_12] The 8-bit pointer is read/write and names any address 0x00 to 0xFF for indirect access.
// [RULE_13] Address 0x00 holds nothing; accesses there go to the address in the pointer.
// [RULE_14] Bank 0 holds port data at 0x05, 0x06 and 0x08; 0x07 is unimplemented.
// [RULE_15] Unused locations read zero and ignore writes with no side effect.
// [RULE_16] Result flags change only on results, stay writable, and a write lands at end of instruction.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module core_status_indirect_regs
(
	input  wire logic                        i_sys_clk,        // 100 MHz system clock
	input  wire logic                        i_rst_n,          // Asynchronous reset, active low
	input  wire logic [7:0]                  i_addr,           // Register address
	input  wire logic [7:0]                  i_wdata,          // Write data
	input  wire logic                        i_wr,             // Write strobe
	input  wire logic                        i_rd,             // Read strobe
	input  wire core_regs_pkg::flag_upd_type i_flags,          // Result flags from datapath
	input  wire core_regs_pkg::core_evt_type i_evt,            // Core instruction and watchdog events
	output logic      [7:0]                  o_rdata,          // Read data, one cycle after strobe
	output logic      [7:0]                  o_status,         // Status register
	output logic      [7:0]                  o_bank_select,    // Bank select register
	output logic      [7:0]                  o_pointer,        // Indirect pointer
	output logic      [7:0]                  o_pc_low,         // Program counter low byte
	output logic      [7:0]                  o_port_a,         // Port A data
	output logic      [7:0]                  o_port_b,         // Port B data
	output logic      [7:0]                  o_port_c,         // Port C data
	output logic                             o_irq_enable      // Interrupt gate
);
	import core_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rst_meta_r;
	logic rst_sync_r;

	// Two flops so release is clean against the clock
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	// Classify a resolved address with the current special bank bit
	function automatic addr_class_type classify(input logic [7:0] a, input logic special_bank);
		if (a >= ADDR_BANKED_FIRST)
			classify = CLS_BANKED;                                     // [RULE_02]
		else if (a >= ADDR_SHARED_FIRST)
			classify = CLS_SHARED;                                     // [RULE_02]
		else if (a == ADDR_INDIRECT_WINDOW)
			classify = CLS_WINDOW;
		else if (a == ADDR_BANK_SELECT)
			classify = CLS_BANKSEL;                                    // [RULE_01]
		else if (a == ADDR_PC_LOW)
			classify = CLS_PCL;
		else if (a == ADDR_STATUS)
			classify = CLS_STATUS;
		else if (a == ADDR_POINTER)
			classify = CLS_POINTER;
		else if (special_bank)
			classify = CLS_UNUSED;                                     // [RULE_03] bank 1 lives elsewhere
		else if (a == ADDR_PORT_A)
			classify = CLS_PORT_A;                                     // [RULE_14]
		else if (a == ADDR_PORT_B)
			classify = CLS_PORT_B;
		else if (a == ADDR_PORT_C)
			classify = CLS_PORT_C;
		else
			classify = CLS_UNUSED;                                     // [RULE_15]
	endfunction

	logic [7:0]     bank_select_r;
	logic [7:0]     pointer_r;
	logic [7:0]     pc_low_r;
	logic [7:0]     port_a_r;
	logic [7:0]     port_b_r;
	logic [7:0]     port_c_r;
	logic [7:0]     rdata_r;
	logic [7:0]     rdata_nxt;
	logic [7:0]     status_val;
	addr_class_type cls;
	logic [7:0]     shared_mem [SHARED_WORDS];
	logic [7:0]     banked_mem [BANKED_WORDS];

	// Bank 1 special registers belong to other blocks, so this slice answers zero for them
	wire            special_bank = bank_select_r[BSEL_SPECIAL_BIT];
	wire            general_bank = bank_select_r[BSEL_GENERAL_BIT];
	// A pointer of zero through the window resolves to the window again: reads zero, writes vanish
	wire [7:0]      eff_addr = (i_addr == ADDR_INDIRECT_WINDOW) ? pointer_r : i_addr;   // [RULE_13] [RULE_12]
	assign cls = classify(eff_addr, special_bank);
	wire            wr_hit = i_wr && rst_sync_r;
	wire            status_wr = wr_hit && (cls == CLS_STATUS);
	wire [5:0]      shared_idx = 6'(eff_addr - ADDR_SHARED_FIRST);
	wire [7:0]      banked_idx = {general_bank, eff_addr[6:0]};       // [RULE_04]

	////////////////////////////////////////////////////////////////////////////
	// Control registers

	// Writes land at the end of the strobe cycle
	always_ff @(posedge i_sys_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			bank_select_r <= RST_ZERO;
			pointer_r     <= RST_ZERO;
			pc_low_r      <= RST_ZERO;
			port_a_r      <= RST_ZERO;
			port_b_r      <= RST_ZERO;
			port_c_r      <= RST_ZERO;
		end
		else if (wr_hit)
		begin
			case (cls)
				CLS_BANKSEL: bank_select_r <= i_wdata & BSEL_MASK;       // [RULE_03] [RULE_04]
				CLS_POINTER: pointer_r     <= i_wdata;                   // [RULE_12]
				CLS_PCL:     pc_low_r      <= i_wdata;
				CLS_PORT_A:  port_a_r      <= i_wdata;                   // [RULE_14]
				CLS_PORT_B:  port_b_r      <= i_wdata;
				CLS_PORT_C:  port_c_r      <= i_wdata;
				default:     ;                                           // [RULE_15]
			endcase
		end
	end

	// Storage arrays carry no reset, so they map onto plain RAM
	always_ff @(posedge i_sys_clk)
	begin
		if (wr_hit && cls == CLS_SHARED)
			shared_mem[shared_idx] <= i_wdata;                         // [RULE_02]
		if (wr_hit && cls == CLS_BANKED)
			banked_mem[banked_idx] <= i_wdata;                         // [RULE_02] [RULE_04]
	end

	////////////////////////////////////////////////////////////////////////////
	// Status register

	status_flag_unit u_status
	(
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (rst_sync_r),
		.i_wr      (status_wr),                                        // [RULE_16]
		.i_wdata   (i_wdata),
		.i_flags   (i_flags),
		.i_evt     (i_evt),
		.o_status  (status_val)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read path

	// Read mux; unused and window-to-window both answer zero
	always_comb
	begin
		case (cls)
			CLS_BANKSEL: rdata_nxt = bank_select_r;
			CLS_PCL:     rdata_nxt = pc_low_r;
			CLS_STATUS:  rdata_nxt = status_val;
			CLS_POINTER: rdata_nxt = pointer_r;
			CLS_PORT_A:  rdata_nxt = port_a_r;
			CLS_PORT_B:  rdata_nxt = port_b_r;
			CLS_PORT_C:  rdata_nxt = port_c_r;
			CLS_SHARED:  rdata_nxt = shared_mem[shared_idx];
			CLS_BANKED:  rdata_nxt = banked_mem[banked_idx];
			default:     rdata_nxt = RST_ZERO;                         // [RULE_15]
		endcase
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge i_sys_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			rdata_r <= RST_ZERO;
		else
			rdata_r <= i_rd ? rdata_nxt : RST_ZERO;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_rdata       = rdata_r;
	assign o_status      = status_val;
	assign o_bank_select = bank_select_r;
	assign o_pointer     = pointer_r;
	assign o_pc_low      = pc_low_r;
	assign o_port_a      = port_a_r;
	assign o_port_b      = port_b_r;
	assign o_port_c      = port_c_r;
	assign o_irq_enable  = status_val[ST_IRQ_EN];

	////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_unused_zero;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_rd && cls == CLS_UNUSED) |=> (o_rdata == RST_ZERO);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused location read nonzero"); // [RULE_15]

	property p_pointer_rw;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_wr && i_addr == ADDR_POINTER) ##1 (i_rd && i_addr == ADDR_POINTER) |=> (o_rdata == $past(i_wdata, 2));
	endproperty
	a_pointer_rw: assert property (p_pointer_rw) else $error("pointer readback wrong"); // [RULE_12]

	property p_window;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_rd && i_addr == ADDR_INDIRECT_WINDOW && pointer_r == ADDR_STATUS) |=> (o_rdata == status_val
			|| $past(i_flags.upd) || $past(i_evt) != '0);
	endproperty
	a_window: assert property (p_window) else $error("window did not reach pointed register"); // [RULE_13]

	property p_special_bank;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_rd && i_addr == ADDR_PORT_A && special_bank) |=> (o_rdata == RST_ZERO);
	endproperty
	a_special_bank: assert property (p_special_bank) else $error("bank 1 special read hit port"); // [RULE_03]

	property p_port_write;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_wr && i_addr == ADDR_PORT_C && !special_bank) |=> (o_port_c == $past(i_wdata));
	endproperty
	a_port_write: assert property (p_port_write) else $error("port write lost"); // [RULE_14]

	property p_bsel_mask;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		1'b1 |-> ((o_bank_select & ~BSEL_MASK) == RST_ZERO);
	endproperty
	a_bsel_mask: assert property (p_bsel_mask) else $error("bank select unused bits set"); // [RULE_01]

	// Write paths and window read: each written register takes the byte, bank select only through its mask; refused writes leave every register alone
	property p_window_write;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_wr && i_addr == ADDR_INDIRECT_WINDOW && pointer_r == ADDR_PORT_A && !special_bank)
			|=> (o_port_a == $past(i_wdata));
	endproperty
	a_window_write: assert property (p_window_write) else $error("window write missed port"); // [RULE_13]

	property p_window_read;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_rd && i_addr == ADDR_INDIRECT_WINDOW && pointer_r == ADDR_PORT_A && !special_bank)
			|=> (o_rdata == $past(o_port_a));
	endproperty
	a_window_read: assert property (p_window_read) else $error("window read missed port"); // [RULE_13]

	property p_window_self;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_wr && i_addr == ADDR_INDIRECT_WINDOW && pointer_r == ADDR_INDIRECT_WINDOW)
			|=> ($stable(o_bank_select) && $stable(o_pointer) && $stable(o_pc_low) && $stable(o_port_a)
			&& $stable(o_port_b) && $stable(o_port_c));
	endproperty
	a_window_self: assert property (p_window_self) else $error("window to itself changed a register"); // [RULE_13]

	property p_special_shield;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_wr && i_addr == ADDR_PORT_A && special_bank) |=> $stable(o_port_a);
	endproperty
	a_special_shield: assert property (p_special_shield) else $error("bank 1 special write hit port"); // [RULE_03]

	property p_bank_write;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_wr && i_addr == ADDR_BANK_SELECT) |=> (o_bank_select == ($past(i_wdata) & BSEL_MASK));
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("bank select write lost"); // [RULE_04]

	property p_unused_write;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_wr && cls == CLS_UNUSED)
			|=> ($stable(o_bank_select) && $stable(o_pointer) && $stable(o_pc_low) && $stable(o_port_a)
			&& $stable(o_port_b) && $stable(o_port_c));
	endproperty
	a_unused_write: assert property (p_unused_write) else $error("unused write changed a register"); // [RULE_15]

	property p_pointer_direct;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_wr && i_addr == ADDR_POINTER) |=> (o_pointer == $past(i_wdata));
	endproperty
	a_pointer_direct: assert property (p_pointer_direct) else $error("pointer write lost"); // [RULE_12]

	property p_pcl_write;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_wr && i_addr == ADDR_PC_LOW) |=> (o_pc_low == $past(i_wdata));
	endproperty
	a_pcl_write: assert property (p_pcl_write) else $error("program counter low write lost"); // [RULE_01]

	property p_port_b_write;
		@(posedge i_sys_clk) disable iff (!rst_sync_r)
		(i_wr && i_addr == ADDR_PORT_B && !special_bank) |=> (o_port_b == $past(i_wdata));
	endproperty
	a_port_b_write: assert property (p_port_b_write) else $error("port B write lost"); // [RULE_14]
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking testbench for the core register slice: map, indirect window, banks and status
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import core_regs_pkg::*;

	logic         i_sys_clk;
	logic         i_rst_n;
	logic [7:0]   i_addr;
	logic [7:0]   i_wdata;
	logic         i_wr;
	logic         i_rd;
	flag_upd_type i_flags;
	core_evt_type i_evt;
	logic [7:0]   o_rdata;
	logic [7:0]   o_status;
	logic [7:0]   o_bank_select;
	logic [7:0]   o_pointer;
	logic [7:0]   o_pc_low;
	logic [7:0]   o_port_a;
	logic [7:0]   o_port_b;
	logic [7:0]   o_port_c;
	logic         o_irq_enable;
	int           errors;
	int           num_checks;

	core_status_indirect_regs dut_u
	(
		.i_sys_clk     (i_sys_clk),
		.i_rst_n       (i_rst_n),
		.i_addr        (i_addr),
		.i_wdata       (i_wdata),
		.i_wr          (i_wr),
		.i_rd          (i_rd),
		.i_flags       (i_flags),
		.i_evt         (i_evt),
		.o_rdata       (o_rdata),
		.o_status      (o_status),
		.o_bank_select (o_bank_select),
		.o_pointer     (o_pointer),
		.o_pc_low      (o_pc_low),
		.o_port_a      (o_port_a),
		.o_port_b      (o_port_b),
		.o_port_c      (o_port_c),
		.o_irq_enable  (o_irq_enable)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock generation
	initial
	begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers; case inequality so an unknown never counts as a match
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One-cycle write; the value lands at the edge that ends the task
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		#1;
	endtask

	// One-cycle read; data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask

	// One-cycle event pulse; status is settled after the taking edge
	task automatic evt(input logic [5:0] e);
		@(posedge i_sys_clk);
		i_evt <= core_evt_type'(e);
		@(posedge i_sys_clk);
		i_evt <= '0;
		#1;
	endtask

	task automatic flg(input logic [5:0] f);
		@(posedge i_sys_clk);
		i_flags <= flag_upd_type'(f);
		@(posedge i_sys_clk);
		i_flags <= '0;
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_reset_values();
		chk(o_status, 8'h18);
		chk({7'h00, o_irq_enable}, 8'h00);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h18);
		rd(8'h04, 8'h00);
	endtask

	task automatic test_core_and_ports();
		wr(8'h01, 8'hFF);
		rd(8'h01, 8'h11);
		chk(o_bank_select, 8'h11);
		wr(8'h01, 8'h00);
		wr(8'h02, 8'hA5);
		rd(8'h02, 8'hA5);
		chk(o_pc_low, 8'hA5);
		wr(8'h05, 8'h11);
		wr(8'h06, 8'h22);
		wr(8'h08, 8'h33);
		wr(8'h07, 8'h77);
		wr(8'h09, 8'h99);
		rd(8'h05, 8'h11);
		rd(8'h06, 8'h22);
		chk(o_port_b, 8'h22);
		rd(8'h08, 8'h33);
		rd(8'h07, 8'h00);
		rd(8'h09, 8'h00);
		chk(o_port_c, 8'h33);
	endtask

	task automatic test_indirect();
		// Pointer still zero: the window points at itself and must hold nothing
		wr(8'h00, 8'h55);
		rd(8'h00, 8'h00);
		wr(8'h04, 8'h90);
		chk(o_pointer, 8'h90);
		wr(8'h00, 8'h5A);
		rd(8'h90, 8'h5A);
		rd(8'h00, 8'h5A);
		wr(8'h04, 8'h05);
		wr(8'h00, 8'hC3);
		chk(o_port_a, 8'hC3);
		rd(8'h00, 8'hC3);
		// Pointer at status: the window reads the status value, still at its power-up state
		wr(8'h04, 8'h03);
		rd(8'h00, 8'h18);
		// Pointer write and read with no gap between the strobes
		@(posedge i_sys_clk);
		i_addr  <= 8'h04;
		i_wdata <= 8'h3C;
		i_wr    <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, 8'h3C);
		wr(8'h04, 8'hFF);
		rd(8'h04, 8'hFF);
	endtask

	task automatic test_storage_banks();
		wr(8'h50, 8'h01);
		wr(8'h7F, 8'h02);
		wr(8'h80, 8'h03);
		wr(8'hFF, 8'h04);
		wr(8'h01, 8'h01);
		rd(8'h50, 8'h01);
		rd(8'h7F, 8'h02);
		wr(8'h80, 8'h13);
		wr(8'hFF, 8'h14);
		rd(8'h80, 8'h13);
		wr(8'h01, 8'h00);
		rd(8'h80, 8'h03);
		rd(8'hFF, 8'h04);
	endtask

	task automatic test_special_bank();
		// Bank 1 special registers live elsewhere, so port A must be shielded
		wr(8'h01, 8'h10);
		wr(8'h05, 8'hEE);
		rd(8'h05, 8'h00);
		chk(o_port_a, 8'hC3);
		rd(8'h03, 8'h18);
		wr(8'h01, 8'h00);
		rd(8'h05, 8'hC3);
	endtask

	task automatic test_result_flags();
		logic [4:0] pat [7];
		pat = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h1F, 5'h00};
		foreach (pat[i])
		begin
			flg({1'b1, pat[i]});
			chk(o_status & 8'h67, {1'b0, pat[i][4:3], 2'b00, pat[i][2:0]});
		end
		// Flags offered without the update pulse are ignored
		flg(6'h1F);
		chk(o_status & 8'h67, 8'h00);
		wr(8'h03, 8'h67);
		chk(o_status & 8'h67, 8'h67);
		// Same-cycle write and result: the result wins
		@(posedge i_sys_clk);
		i_addr  <= 8'h03;
		i_wdata <= 8'h00;
		i_wr    <= 1'b1;
		i_flags <= flag_upd_type'(6'h25);
		@(posedge i_sys_clk);
		i_wr    <= 1'b0;
		i_flags <= '0;
		#1 chk(o_status & 8'h67, 8'h05);
	endtask

	task automatic test_events();
		evt(6'h10);
		chk({7'h00, o_irq_enable}, 8'h01);
		evt(6'h20);
		chk(o_status & 8'h80, 8'h00);
		evt(6'h10);
		evt(6'h08);
		chk({7'h00, o_irq_enable}, 8'h00);
		evt(6'h30);
		chk({7'h00, o_irq_enable}, 8'h00);
		evt(6'h04);
		chk(o_status & 8'h18, 8'h10);
		evt(6'h01);
		chk(o_status & 8'h18, 8'h00);
		evt(6'h02);
		chk(o_status & 8'h18, 8'h18);
		evt(6'h05);
		chk(o_status & 8'h18, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset for three cycles, then wait out the internal synchroniser
	initial
	begin
		errors     = 0;
		num_checks = 0;
		i_rst_n    = 1'b0;
		i_addr     = 8'h00;
		i_wdata    = 8'h00;
		i_wr       = 1'b0;
		i_rd       = 1'b0;
		i_flags    = '0;
		i_evt      = '0;
		repeat (3) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		#1;
		test_reset_values();
		test_core_and_ports();
		test_indirect();
		test_storage_banks();
		test_special_bank();
		test_result_flags();
		test_events();
		complete_run();
	end

	// Watchdog: the run needs well under a thousand cycles
	initial
	begin
		#100000;
		errors++;
		complete_run();
	end
endmodule
`default_nettype wire
